// >>> rtl/tse_map.vh
`ifndef TSE_MAP_VH
`define TSE_MAP_VH
// Register offsets (byte addresses)
`define TSE_REG_CTRL   8'h00
`define TSE_REG_TBASE  8'h04
`define TSE_REG_STATE  8'h08
`define TSE_REG_ISTAT  8'h0c
`define TSE_REG_IMASK  8'h10
// Control register fields
`define TSE_CTRL_ET    0
`define TSE_CTRL_S     1
`define TSE_CTRL_PS    2
`define TSE_CTRL_CWP   8
// Status register fields
`define TSE_ST_ERR     0
`define TSE_ST_BUSY    1
`define TSE_ST_TT      8
// Interrupt event bits
`define TSE_EV_TAKEN   0
`define TSE_EV_ERROR   1
`define TSE_EV_RESET   2
`define TSE_EV_W       3
// Exception flag indices, highest priority first
`define TSE_F_DSTORE   0
`define TSE_F_IACCERR  1
`define TSE_F_RFERR    2
`define TSE_F_IACCEXC  3
`define TSE_F_PRIV     4
`define TSE_F_ILLEGAL  5
`define TSE_F_FPDIS    6
`define TSE_F_CPDIS    7
`define TSE_F_FLUSH    8
`define TSE_F_WOVF     9
`define TSE_F_WUNF     10
`define TSE_F_ALIGN    11
`define TSE_F_FPEXC    12
`define TSE_F_CPEXC    13
`define TSE_F_DACCERR  14
`define TSE_F_DACCEXC  15
`define TSE_F_TAGOVF   16
`define TSE_F_DIVZERO  17
`define TSE_F_SWTRAP   18
`define TSE_NFLAGS     19
// Flags cleared after selection (errors 0,1,2,14 are kept)
`define TSE_CLR_MASK   19'h7bff8
// Trap type codes
`define TSE_TT_DSTORE  8'h2b
`define TSE_TT_IACCERR 8'h21
`define TSE_TT_RFERR   8'h20
`define TSE_TT_IACCEXC 8'h01
`define TSE_TT_PRIV    8'h03
`define TSE_TT_ILLEGAL 8'h02
`define TSE_TT_FPDIS   8'h04
`define TSE_TT_CPDIS   8'h24
`define TSE_TT_FLUSH   8'h25
`define TSE_TT_WOVF    8'h05
`define TSE_TT_WUNF    8'h06
`define TSE_TT_ALIGN   8'h05
`define TSE_TT_FPEXC   8'h28
`define TSE_TT_CPEXC   8'h28
`define TSE_TT_DACCERR 8'h29
`define TSE_TT_DACCEXC 8'h09
`define TSE_TT_TAGOVF  8'h0a
`define TSE_TT_DIVZERO 8'h29
`define TSE_TT_IRQHI   4'h1
// Counter step and reset vectors
`define TSE_PC_STEP    32'h00000004
`define TSE_RST_PC     32'h00000000
`define TSE_RST_NPC    32'h00000004
`endif

// >>> rtl/tse_trap_unit.v
`timescale 1ns/1ps
`include "tse_map.vh"

// Behaviour
// RULE1: Select first, then update state in later cycles
// RULE2: Reset trap ignores enable, keeps trap code
// RULE3: Trap while disabled enters halted error state
// RULE4: Entry clears enable, saves supervisor, decrements window
// RULE5: Save counters into locals, annul shifts them
// RULE6: Set supervisor, jump to trap base
// RULE7: Reset trap jumps to zero, clears reset flag
// RULE8: Store, fetch, register-file errors rank highest
// RULE9: Fetch exception, privileged, illegal follow
// RULE10: Fp disabled, cp disabled, flush follow
// RULE11: Window overflow then underflow
// RULE12: Misaligned address after underflow, code as printed
// RULE13: Fp then cp exception, shared printed code
// RULE14: Data error, data exception, tag overflow
// RULE15: Divide by zero after tag overflow
// RULE16: Software trap code is one plus number
// RULE17: Nonzero interrupt level lowest, code 0001 plus level
// RULE18: Clear listed flags after selection, keep errors
// RULE19: Error state halts issue until reset trap
module tse_trap_unit #(
	parameter WIN_COUNT = 8,         // Implemented register windows
	parameter CWP_W     = 5          // Window pointer width
) (
	// Clock and reset
	input  wire              mclk,
	input  wire              reset_n,
	// Register port
	input  wire [7:0]        regAddr,
	input  wire [31:0]       regWrData,
	input  wire              regWr,
	input  wire              regRd,
	output reg  [31:0]       regRdData,
	// Exception events from the pipeline
	input  wire [18:0]       excEvent,
	input  wire [6:0]        swTrapNum,
	input  wire [3:0]        irqLevelIn,
	input  wire              resetTrapReq,
	// Pipeline counters and annul
	input  wire [31:0]       pcIn,
	input  wire [31:0]       npcIn,
	input  wire              annulIn,
	output reg               annulClear,
	// Local register saves
	output reg               localSaveEn,
	output reg  [31:0]       local17Data,
	output reg  [31:0]       local18Data,
	// Fetch redirect
	output reg               redirectEn,
	output reg  [31:0]       programCounter,
	output reg  [31:0]       nextProgramCounter,
	// Processor state
	output reg               trapsAllowedBit,
	output reg               supervisorFlag,
	output reg               priorSupervisorFlag,
	output reg  [CWP_W-1:0]  currentWindowPointer,
	output reg  [7:0]        trapTypeCode,
	output reg               errorMode,
	output wire              executeMode,
	output wire              issueStall,
	// Interrupt
	output wire              irq
);

	// Trap walk in short:
	// - events set sticky flags; a nonzero level is latched the same way
	// - a pending trap moves RUN to SEL, where only the code is chosen
	// - ENT turns traps off, saves the supervisor bit and rotates the window
	// - SAVE hands the counter pair to the locals, honouring a pending annul
	// - REDIR enters supervisor and points fetch at the handler or at zero
	// A trap other than a reset trap, taken with traps off, parks the unit in ERR with issue stalled.
	// Each step costs one clock; the pipeline must hold issue while busy.
	// Software writes to the control fields lose against a step
	// that updates the same field in that cycle.

	// Sequencer states
	// One trap walks RUN, SEL, ENT, SAVE, REDIR and back to RUN.
	// SEL only latches the code, or the halt when traps are off; the control fields do not move there.
	// ERR is a dead end that only a reset trap can leave.
	// Codes are dense; unused codes fall back to RUN.
	localparam ST_RUN   = 3'd0;
	localparam ST_SEL   = 3'd1;
	localparam ST_ENT   = 3'd2;
	localparam ST_SAVE  = 3'd3;
	localparam ST_REDIR = 3'd4;
	localparam ST_ERR   = 3'd5;

	// Highest window index, cut to the pointer width where it is used
	// Software must keep the pointer below the window count
	localparam [31:0] CWP_LAST = WIN_COUNT - 1;

	// Sequencer and latched trap inputs
	reg  [2:0]                state;         // Sequencer state
	reg  [`TSE_NFLAGS-1:0]    excFlag;       // Pending exception flags
	reg  [6:0]                swNum;         // Latched software trap number
	reg  [3:0]                irqLevel;      // Latched interrupt level
	reg                       resetTrap;     // Reset trap pending
	// Software visible registers
	reg  [31:0]               trapBase;      // Trap base register
	reg  [`TSE_EV_W-1:0]      intStat;       // Sticky events
	reg  [`TSE_EV_W-1:0]      intMask;       // Event mask
	// Helpers that never leave the block
	reg  [`TSE_EV_W-1:0]      evPulse;       // Events this cycle
	reg  [7:0]                selCode;       // Winning code
	// Decoded conditions
	wire                      trapPending;   // Any trap condition
	wire                      clrFlags;      // Selection done this cycle

	// Some causes share one code value; rank alone tells them apart,
	// so a handler cannot tell such a pair from the code by itself.
	// Index and code tables must be kept in step with each other.
	// Unused indices give zero, which no cause uses.
	// Code of one flag index; software trap handled by caller
	function [7:0] flagCode;
		input [4:0] idx;
		begin
			case (idx)
				`TSE_F_DSTORE:  flagCode = `TSE_TT_DSTORE;  // [RULE8]
				`TSE_F_IACCERR: flagCode = `TSE_TT_IACCERR; // [RULE8]
				`TSE_F_RFERR:   flagCode = `TSE_TT_RFERR;   // [RULE8]
				`TSE_F_IACCEXC: flagCode = `TSE_TT_IACCEXC; // [RULE9]
				`TSE_F_PRIV:    flagCode = `TSE_TT_PRIV;    // [RULE9]
				`TSE_F_ILLEGAL: flagCode = `TSE_TT_ILLEGAL; // [RULE9]
				`TSE_F_FPDIS:   flagCode = `TSE_TT_FPDIS;   // [RULE10]
				`TSE_F_CPDIS:   flagCode = `TSE_TT_CPDIS;   // [RULE10]
				`TSE_F_FLUSH:   flagCode = `TSE_TT_FLUSH;   // [RULE10]
				`TSE_F_WOVF:    flagCode = `TSE_TT_WOVF;    // [RULE11]
				`TSE_F_WUNF:    flagCode = `TSE_TT_WUNF;    // [RULE11]
				`TSE_F_ALIGN:   flagCode = `TSE_TT_ALIGN;   // [RULE12]
				`TSE_F_FPEXC:   flagCode = `TSE_TT_FPEXC;   // [RULE13]
				`TSE_F_CPEXC:   flagCode = `TSE_TT_CPEXC;   // [RULE13]
				`TSE_F_DACCERR: flagCode = `TSE_TT_DACCERR; // [RULE14]
				`TSE_F_DACCEXC: flagCode = `TSE_TT_DACCEXC; // [RULE14]
				`TSE_F_TAGOVF:  flagCode = `TSE_TT_TAGOVF;  // [RULE14]
				`TSE_F_DIVZERO: flagCode = `TSE_TT_DIVZERO; // [RULE15]
				default:        flagCode = 8'h00;
			endcase
		end
	endfunction

	// Any flag or a nonzero level asks for a trap
	assign trapPending = (|excFlag) | (irqLevel != 4'h0);
	// Flags drop on the edge that leaves selection
	assign clrFlags    = (state == ST_SEL);
	// Run flag is the inverse of the halt
	assign executeMode = ~errorMode;
	// Issue holds for the whole trap walk and while halted
	assign issueStall  = (state != ST_RUN);      // [RULE19]
	// Level interrupt from unmasked sticky bits
	assign irq         = |(intStat & intMask);

	// Interrupt level is the floor; any flag overrides it.
	// A loop keeps the rank order in one place, the flag index.
	// Priority encoder: scan from lowest so highest wins
	integer i;
	always @* begin
		selCode = 8'h00;
		if (irqLevel != 4'h0)
			selCode = {`TSE_TT_IRQHI, irqLevel};       // [RULE17]
		for (i = `TSE_NFLAGS - 1; i >= 0; i = i - 1) begin
			if (excFlag[i]) begin
				if (i == `TSE_F_SWTRAP)
					selCode = {1'b1, swNum};         // [RULE16]
				else
					selCode = flagCode(i[4:0]);
			end
		end
	end

	// Error flags 0, 1, 2 and 14 survive selection and retrap
	// with traps off, which parks the unit in the error state.
	// Only a full reset drops them.
	// Exception flags: new events win over the clear
	always @(posedge mclk) begin
		if (!reset_n) begin
			excFlag  <= {`TSE_NFLAGS{1'b0}};
			swNum    <= 7'h00;
			irqLevel <= 4'h0;
		end else begin
			if (clrFlags)
				excFlag <= (excFlag & ~`TSE_CLR_MASK) | excEvent; // [RULE18]
			else
				excFlag <= excFlag | excEvent;
			// Trap number held with its flag
			if (excEvent[`TSE_F_SWTRAP])
				swNum <= swTrapNum;
			// Interrupt level follows requests, clears on selection
			if (irqLevelIn != 4'h0)
				irqLevel <= irqLevelIn;
			else if (clrFlags)
				irqLevel <= 4'h0;                      // [RULE18]
		end
	end

	// Trap sequencer and processor state
	// Power-up behaves like a reset trap so the counters
	// and the window are set up the same way as later.
	// Pulses default low and are raised for one cycle only.
	// Control fields come up as supervisor with traps off.
	always @(posedge mclk) begin
		if (!reset_n) begin
			state                <= ST_RUN;
			resetTrap            <= 1'b1;   // Power-up runs a reset trap
			errorMode            <= 1'b0;
			trapTypeCode         <= 8'h00;
			trapsAllowedBit      <= 1'b0;
			supervisorFlag       <= 1'b1;
			priorSupervisorFlag  <= 1'b0;
			currentWindowPointer <= {CWP_W{1'b0}};
			trapBase             <= 32'h00000000;
			programCounter       <= `TSE_RST_PC;
			nextProgramCounter   <= `TSE_RST_NPC;
			local17Data          <= 32'h00000000;
			local18Data          <= 32'h00000000;
			localSaveEn          <= 1'b0;
			redirectEn           <= 1'b0;
			annulClear           <= 1'b0;
			evPulse              <= {`TSE_EV_W{1'b0}};
		end else begin
			localSaveEn <= 1'b0;
			redirectEn  <= 1'b0;
			annulClear  <= 1'b0;
			evPulse     <= {`TSE_EV_W{1'b0}};
			if (resetTrapReq)
				resetTrap <= 1'b1;
			// Software writes; the sequencer below overrides
			if (regWr && regAddr == `TSE_REG_CTRL) begin
				trapsAllowedBit      <= regWrData[`TSE_CTRL_ET];
				supervisorFlag       <= regWrData[`TSE_CTRL_S];
				priorSupervisorFlag  <= regWrData[`TSE_CTRL_PS];
				currentWindowPointer <= regWrData[`TSE_CTRL_CWP +: CWP_W];
			end
			if (regWr && regAddr == `TSE_REG_TBASE)
				trapBase <= regWrData;
			case (state)
				// Running: wait for a trap condition
				// A request still in flight counts as pending
				ST_RUN: begin
					if (resetTrap || resetTrapReq || trapPending)
						state <= ST_SEL;         // [RULE1]
				end

				// Selection: the code is latched, or the halt entered; control fields untouched yet
				// Reset trap ranks above the enable and the code
				ST_SEL: begin
					if (resetTrap) begin
						state <= ST_ENT;         // [RULE2]
					end else if (!trapsAllowedBit) begin
						errorMode <= 1'b1;       // [RULE3]
						evPulse[`TSE_EV_ERROR] <= 1'b1;
						state <= ST_ERR;
					end else begin
						trapTypeCode <= selCode; // [RULE8]
						state <= ST_ENT;
					end
				end

				// Disable traps, save supervisor, rotate window
				ST_ENT: begin
					trapsAllowedBit     <= 1'b0;           // [RULE4]
					priorSupervisorFlag <= supervisorFlag; // [RULE4]
					// Window zero wraps to the highest implemented window
					if (currentWindowPointer == {CWP_W{1'b0}})
						currentWindowPointer <= CWP_LAST[CWP_W-1:0]; // [RULE4]
					else
						currentWindowPointer <= currentWindowPointer - 1'b1;
					state <= ST_SAVE;
				end

				// Save counter pair into locals 17 and 18
				// Stall froze the counters, so this is the trapped pair
				ST_SAVE: begin
					localSaveEn <= 1'b1;
					if (!annulIn) begin
						local17Data <= pcIn;             // [RULE5]
						local18Data <= npcIn;            // [RULE5]
					end else begin
						local17Data <= npcIn;            // [RULE5]
						local18Data <= npcIn + `TSE_PC_STEP;
						annulClear  <= 1'b1;             // [RULE5]
					end
					state <= ST_REDIR;
				end

				// Enter supervisor and redirect fetch
				// A request here keeps the reset flag for one more pass
				ST_REDIR: begin
					supervisorFlag <= 1'b1;                  // [RULE6]
					redirectEn     <= 1'b1;
					if (!resetTrap) begin
						programCounter     <= trapBase;      // [RULE6]
						nextProgramCounter <= trapBase + `TSE_PC_STEP;
						evPulse[`TSE_EV_TAKEN] <= 1'b1;
					end else begin
						programCounter     <= `TSE_RST_PC;   // [RULE7]
						nextProgramCounter <= `TSE_RST_NPC;  // [RULE7]
						resetTrap          <= resetTrapReq;  // [RULE7]
						evPulse[`TSE_EV_RESET] <= 1'b1;
					end
					state <= ST_RUN;
				end

				// Halted: only a reset trap leaves
				// Pending flags stay; the reset trap ignores them
				ST_ERR: begin
					if (resetTrap || resetTrapReq) begin
						errorMode <= 1'b0;                   // [RULE19]
						state     <= ST_SEL;
					end
				end
				default: state <= ST_RUN;
			endcase
		end
	end

	// Event pulses come one cycle after the step that caused them.
	// Masking only gates the line; status still records events.
	// Sticky interrupt status; an event beats a write-one clear
	always @(posedge mclk) begin
		if (!reset_n) begin
			intStat <= {`TSE_EV_W{1'b0}};
			intMask <= {`TSE_EV_W{1'b0}};
		end else begin
			if (regWr && regAddr == `TSE_REG_ISTAT)
				intStat <= (intStat & ~regWrData[`TSE_EV_W-1:0]) | evPulse;
			else
				intStat <= intStat | evPulse;
			if (regWr && regAddr == `TSE_REG_IMASK)
				intMask <= regWrData[`TSE_EV_W-1:0];
		end
	end

	// Register map:
	// 0x00 control: enable, supervisor, prior supervisor, window pointer
	// 0x04 trap base address, full word
	// 0x08 state, read only: halt, busy, last trap code
	// 0x0c event status, write one to clear
	// 0x10 event mask, same layout as status
	// Data stands for one cycle only, so a late look sees zero.
	// Read data one cycle after the strobe; unmapped reads zero
	always @(posedge mclk) begin
		if (!reset_n) begin
			regRdData <= 32'h00000000;
		end else if (regRd) begin
			regRdData <= 32'h00000000;
			case (regAddr)
				`TSE_REG_CTRL: begin
					regRdData[`TSE_CTRL_ET] <= trapsAllowedBit;
					regRdData[`TSE_CTRL_S]  <= supervisorFlag;
					regRdData[`TSE_CTRL_PS] <= priorSupervisorFlag;
					regRdData[`TSE_CTRL_CWP +: CWP_W] <= currentWindowPointer;
				end
				`TSE_REG_TBASE: regRdData <= trapBase;
				`TSE_REG_STATE: begin
					regRdData[`TSE_ST_ERR]    <= errorMode;
					regRdData[`TSE_ST_BUSY]   <= (state != ST_RUN);
					regRdData[`TSE_ST_TT +: 8] <= trapTypeCode;
				end
				`TSE_REG_ISTAT: regRdData[`TSE_EV_W-1:0] <= intStat;
				`TSE_REG_IMASK: regRdData[`TSE_EV_W-1:0] <= intMask;
				default: regRdData <= 32'h00000000;
			endcase
		end else begin
			regRdData <= 32'h00000000;
		end
	end

endmodule

// >>> test/tse_trap_monitor.sv
`timescale 1ns/1ps
// Watches trap entry sequencing at the unit's ports
module tse_trap_monitor #(
	parameter WIN_COUNT = 8,
	parameter CWP_W     = 5
) (
	// Clock and reset
	input wire             mclk,
	input wire             reset_n,
	// Counters and local saves
	input wire [31:0]      pcIn,
	input wire [31:0]      npcIn,
	input wire             annulClear,
	input wire             localSaveEn,
	input wire [31:0]      local17Data,
	input wire [31:0]      local18Data,
	input wire             redirectEn,
	input wire [31:0]      programCounter,
	input wire [31:0]      nextProgramCounter,
	// Processor state
	input wire             supervisorFlag,
	input wire             priorSupervisorFlag,
	input wire             trapsAllowedBit,
	input wire [CWP_W-1:0] currentWindowPointer,
	input wire             errorMode,
	input wire             executeMode,
	input wire             issueStall
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	// Save step, then the jump step
	sequence s_save;
		localSaveEn;
	endsequence
	sequence s_redir;
		redirectEn && supervisorFlag;
	endsequence
	property p_order;
		s_save |=> s_redir ##1 !redirectEn;
	endproperty
	a_order: assert property (p_order) else $error("jump did not follow save");
	// State of entry is two cycles old by the save
	property p_entry;
		s_save |-> !trapsAllowedBit && priorSupervisorFlag == $past(supervisorFlag, 2);
	endproperty
	a_entry: assert property (p_entry) else $error("entry state wrong");
	property p_cwp;
		s_save |-> currentWindowPointer == ($past(currentWindowPointer, 2) + WIN_COUNT - 1)
			% WIN_COUNT;
	endproperty
	a_cwp: assert property (p_cwp) else $error("window not rotated");
	// Counters are taken one cycle before the save pulse
	property p_annul;
		annulClear |-> s_save ##0 (local17Data == $past(npcIn) && local18Data == $past(npcIn) + 32'h4);
	endproperty
	a_annul: assert property (p_annul) else $error("annulled save wrong");
	property p_plain;
		s_save ##0 !annulClear |-> local17Data == $past(pcIn) && local18Data == $past(npcIn);
	endproperty
	a_plain: assert property (p_plain) else $error("plain save wrong");
	property p_vec;
		redirectEn |-> nextProgramCounter == programCounter + 32'h4;
	endproperty
	a_vec: assert property (p_vec) else $error("counter pair wrong");
	// No trap work while halted
	property p_halt;
		errorMode |-> issueStall && !localSaveEn && !redirectEn;
	endproperty
	a_halt: assert property (p_halt) else $error("halted unit acted");
	property p_exec;
		$rose(errorMode) |-> !executeMode && !trapsAllowedBit;
	endproperty
	a_exec: assert property (p_exec) else $error("halt entered with traps on");
endmodule

bind tse_trap_unit tse_trap_monitor #(.WIN_COUNT(WIN_COUNT), .CWP_W(CWP_W)) u_tse_trap_monitor (
	.mclk, .reset_n, .pcIn, .npcIn, .annulClear, .localSaveEn, .local17Data, .local18Data,
	.redirectEn, .programCounter, .nextProgramCounter, .supervisorFlag, .priorSupervisorFlag,
	.trapsAllowedBit, .currentWindowPointer, .errorMode, .executeMode, .issueStall);

// >>> test/tse_pipe_model.sv
`timescale 1ns/1ps
// Pipeline side: counters move while issue runs
module tse_pipe_model (
	// Clock and reset
	input wire        mclk,
	input wire        reset_n,
	// From the trap unit and bench
	input wire        issueStall,
	input wire        annulClear,
	input wire        annulReq,
	// To the trap unit
	output reg [31:0] pcIn,
	output reg [31:0] npcIn,
	output reg        annulIn
);
	// Frozen counters during a trap keep the saved pair stable
	always @(posedge mclk) begin
		if (!reset_n) begin
			pcIn <= 32'h00001000;
			npcIn <= 32'h00001004;
			annulIn <= 1'b0;
		end else begin
			if (!issueStall) begin
				pcIn <= npcIn;
				npcIn <= npcIn + 32'h4;
			end
			// Annul stays pending until the unit clears it
			if (annulClear)
				annulIn <= 1'b0;
			else if (annulReq)
				annulIn <= 1'b1;
		end
	end
endmodule

// >>> test/tb.sv
`timescale 1ns/1ps
`include "tse_map.vh"
module tb;
	// Bench driven inputs
	reg         mclk = 1'b0;
	reg         reset_n = 1'b0;
	reg  [7:0]  regAddr = 8'h00;
	reg  [31:0] regWrData = 32'h0;
	reg         regWr = 1'b0;
	reg         regRd = 1'b0;
	reg  [18:0] excEvent = 19'h0;
	reg  [6:0]  swTrapNum = 7'h5a;
	reg  [3:0]  irqLevelIn = 4'h0;
	reg         resetTrapReq = 1'b0;
	reg         annulReq = 1'b0;
	// Unit outputs
	wire [31:0] regRdData, pcIn, npcIn, local17Data, local18Data, programCounter, nextProgramCounter;
	wire        annulIn, annulClear, localSaveEn, redirectEn, trapsAllowedBit, supervisorFlag;
	wire        priorSupervisorFlag, errorMode, executeMode, issueStall, irq;
	wire [4:0]  currentWindowPointer;
	wire [7:0]  trapTypeCode;
	reg  [31:0] rdv;
	integer     err_total = 0;
	integer     n_compared = 0;
	integer     i;
	// Codes by flag index, lowest index in the low byte
	localparam [143:0] TT_TAB = {`TSE_TT_DIVZERO, `TSE_TT_TAGOVF, `TSE_TT_DACCEXC,
		`TSE_TT_DACCERR, `TSE_TT_CPEXC, `TSE_TT_FPEXC, `TSE_TT_ALIGN, `TSE_TT_WUNF, `TSE_TT_WOVF,
		`TSE_TT_FLUSH, `TSE_TT_CPDIS, `TSE_TT_FPDIS, `TSE_TT_ILLEGAL, `TSE_TT_PRIV,
		`TSE_TT_IACCEXC, `TSE_TT_RFERR, `TSE_TT_IACCERR, `TSE_TT_DSTORE};
	tse_trap_unit u_tse_trap_unit (.mclk, .reset_n, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData, .excEvent, .swTrapNum, .irqLevelIn, .resetTrapReq, .pcIn, .npcIn, .annulIn,
		.annulClear, .localSaveEn, .local17Data, .local18Data, .redirectEn, .programCounter,
		.nextProgramCounter, .trapsAllowedBit, .supervisorFlag, .priorSupervisorFlag,
		.currentWindowPointer, .trapTypeCode, .errorMode, .executeMode, .issueStall, .irq);
	tse_pipe_model u_tse_pipe_model (.mclk, .reset_n, .issueStall, .annulClear, .annulReq,
		.pcIn, .npcIn, .annulIn);
	initial forever #12.5 mclk = ~mclk;
	task chk(input string nm, input [31:0] exp, input [31:0] got);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				err_total = err_total + 1;
				$display("[ERR] %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	// One cycle write; settles before return
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge mclk);
			regAddr <= a;
			regWrData <= d;
			regWr <= 1'b1;
			@(posedge mclk);
			regWr <= 1'b0;
			#1;
		end
	endtask
	task rd(input [7:0] a);
		begin
			@(posedge mclk);
			regAddr <= a;
			regRd <= 1'b1;
			@(posedge mclk);
			regRd <= 1'b0;
			#1 rdv = regRdData;
		end
	endtask
	// Events, level and annul for one edge
	task pulse(input [18:0] ev, input [3:0] lvl, input ann);
		begin
			@(posedge mclk);
			excEvent <= ev;
			irqLevelIn <= lvl;
			annulReq <= ann;
			@(posedge mclk);
			excEvent <= 19'h0;
			irqLevelIn <= 4'h0;
			annulReq <= 1'b0;
		end
	endtask
	// Bounded wait for the jump pulse or the halt
	task wait_on(input sel);
		integer k;
		begin
			for (k = 0; k < 40 && (sel ? errorMode : redirectEn) !== 1'b1; k = k + 1)
				@(posedge mclk) #1;
			chk("wait", 1, sel ? errorMode : redirectEn);
		end
	endtask
	task t_reset;
		begin
			wait_on(0);
			chk("pc", `TSE_RST_PC, programCounter);
			chk("npc", `TSE_RST_NPC, nextProgramCounter);
			chk("tt", 0, trapTypeCode);
			chk("cwp", 7, currentWindowPointer);
			rd(`TSE_REG_ISTAT);
			chk("istat", 4, rdv);
			rd(8'h14);
			chk("unmapped", 0, rdv);
		end
	endtask
	// Flags 3 to 18 but 14, each but 13 with its lower neighbour (18 with a level); the higher must win
	task t_prio;
		integer n;
		reg [18:0] ev;
		begin
			wr(`TSE_REG_TBASE, 32'h00000400);
			for (n = 18; n > 2; n = n - 1) begin
				if (n != 14) begin
					wr(`TSE_REG_CTRL, 32'h1);
					ev = (19'h1 << n) | ((n < 18 && n != 13) ? 19'h1 << (n + 1) : 19'h0);
					pulse(ev, (n == 18) ? 4'h9 : 4'h0, n == 5);
					wait_on(0);
					chk("tt", (n == 18) ? 8'hda : TT_TAB[8*n +: 8], trapTypeCode);
					chk("pc", 32'h400, programCounter);
					chk("s", 1, supervisorFlag);
					chk("ps", 0, priorSupervisorFlag);
					chk("annul", 0, annulIn);
					repeat (8) @(posedge mclk);
					#1;
					chk("no retrap", 0, errorMode);
				end
			end
		end
	endtask
	task t_irq;
		begin
			wr(`TSE_REG_CTRL, 32'h1);
			wr(`TSE_REG_IMASK, 32'h0);
			wr(`TSE_REG_ISTAT, 32'h7);
			pulse(19'h0, 4'h9, 1'b0);
			wait_on(0);
			chk("tt", {`TSE_TT_IRQHI, 4'h9}, trapTypeCode);
			rd(`TSE_REG_ISTAT);
			chk("istat", 1, rdv);
			chk("irq masked", 0, irq);
			wr(`TSE_REG_IMASK, 32'h1);
			chk("irq", 1, irq);
			wr(`TSE_REG_ISTAT, 32'h1);
			chk("irq cleared", 0, irq);
		end
	endtask
	// Kept error flag retraps with traps off and halts
	task t_sticky(input integer k);
		begin
			@(posedge mclk);
			reset_n <= 1'b0;
			repeat (3) @(posedge mclk);
			reset_n <= 1'b1;
			wait_on(0);
			wr(`TSE_REG_CTRL, 32'h1);
			pulse((19'h1 << k) | (19'h1 << 16), 4'h0, 1'b0);
			wait_on(0);
			chk("tt", TT_TAB[8*k +: 8], trapTypeCode);
			wait_on(1);
			chk("halt", 1, issueStall);
			rd(`TSE_REG_ISTAT);
			chk("istat err", 2, rdv & 32'h2);
			@(posedge mclk);
			resetTrapReq <= 1'b1;
			@(posedge mclk);
			resetTrapReq <= 1'b0;
			wait_on(0);
			chk("pc", `TSE_RST_PC, programCounter);
			chk("tt kept", TT_TAB[8*k +: 8], trapTypeCode);
			chk("err left", 0, errorMode);
		end
	endtask
	task give_verdict;
		begin
			$display("compared %0d errors %0d", n_compared, err_total);
			if (err_total == 0 && n_compared > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// Watchdog far beyond the expected few hundred cycles
	initial begin
		#(25 * 50000);
		err_total = err_total + 1;
		give_verdict;
	end
	initial begin
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset;
		t_prio;
		t_irq;
		for (i = 0; i < 4; i = i + 1)
			t_sticky(i == 3 ? 14 : i);
		give_verdict;
	end
endmodule
